/* File: design/tses_sequencer.sv */
`timescale 1ns/100ps
`include "tses_defines.svh"
// Function
// - free-run starts frames as fast as allowed
// - valid rate request enters fixed-rate mode
// - clearing fixed-rate bit returns to free-run
// - trigger only when enabled, on isolated pair
// - trigger delay before strobe asserts
// - delay counted in time or encoder steps
// - trigger resynchronised to sensor line rate
// - exposure starts after fixed turn-on interval
// - exposure pulse width equals programmed time, one cycle when programmed zero
// - strobe drops at end of exposure
// - exposure end starts readout
// - period measured exposure start to start
// - over-rate triggers are ignored
// - max rate from scan limit and period
// - max rate readable as status
// - unstrobed readouts never overlap
// - strobe waits for previous readout done
// - min period sum, maxed with delay
// - only timed delay enters rate calculation
// - readout duration per scan and variant
// - reduced scan modes shorten readout
// - strobe is a level spanning exposure
module tses_sequencer
  import tses_pkg::*;
#(
  parameter int RO_FULL_A_US = 16380,
  parameter int RO_HALF_A_US = 8860,
  parameter int RO_QUARTER_A_US = 5490,
  parameter int RO_BIN_A_US = 8170,
  parameter int RO_FULL_B_US = 76470,
  parameter int RO_HALF_B_US = 41380,
  parameter int RO_QUARTER_B_US = 24700,
  parameter int RO_BIN_B_US = 38230
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // trigger pins and encoder
  input wire logic isolated_trigger_in_pos,
  input wire logic isolated_trigger_in_neg,
  input wire logic encoder_step,
  // light and sensor
  output logic strobe_out,
  output logic exposure_out,
  output logic readout_start,
  output logic readout_active
);

  localparam logic [31:0] SYNC_A_CYC = 32'(`TSES_SYNC_A_NS / `TSES_CLK_NS);
  localparam logic [31:0] SYNC_B_CYC = 32'(`TSES_SYNC_B_NS / `TSES_CLK_NS);
  localparam logic [31:0] TON_A_CYC = 32'(`TSES_TURNON_A_NS / `TSES_CLK_NS);
  localparam logic [31:0] TON_B_CYC = 32'(`TSES_TURNON_B_NS / `TSES_CLK_NS);
  localparam logic [31:0] CYC_PER_US = 32'(`TSES_CYC_PER_US);
  localparam logic [31:0] RO_TAB_A [0:3] = '{32'(RO_FULL_A_US), 32'(RO_HALF_A_US),
                                             32'(RO_QUARTER_A_US), 32'(RO_BIN_A_US)};
  localparam logic [31:0] RO_TAB_B [0:3] = '{32'(RO_FULL_B_US), 32'(RO_HALF_B_US),
                                             32'(RO_QUARTER_B_US), 32'(RO_BIN_B_US)};

  function automatic logic [31:0] us_to_cyc(input logic [23:0] v);
    us_to_cyc = {8'h00, v} * CYC_PER_US;
  endfunction

  logic rst_s1_q, rst_n_q;
  logic ack_q;
  logic [31:0] avs_readdata_q;
  logic [6:0] ctrl_q;
  logic fixed_q;
  logic [19:0] exp_us_q, dly_q;
  logic [23:0] req_us_q;
  logic missed_q;
  logic [15:0] miss_cnt_q;
  logic [2:0] pos_sync_q, neg_sync_q;
  logic trig_lvl_q, trig_prev_q;
  logic [10:0] line_cnt_q;
  tses_state_type state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [31:0] since_q;
  logic [31:0] ro_cnt_q;
  logic ro_pend_q;
  logic strobe_q, exposure_q, ro_start_q, ro_act_q;
  logic [5:0] div_cnt_q;
  logic [32:0] div_rem_q;
  logic [31:0] div_quo_q, div_den_q, rate_q;

  // reset release through two flops, async assert
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // configuration decode
  wire trig_en = ctrl_q[`TSES_CTRL_TRIG_EN];
  wire trig_fall = ctrl_q[`TSES_CTRL_TRIG_FALL];
  wire strobe_en = ctrl_q[`TSES_CTRL_STROBE_EN];
  wire dly_counts = ctrl_q[`TSES_CTRL_DLY_COUNTS];
  wire variant = ctrl_q[`TSES_CTRL_VARIANT];
  wire [1:0] scan = ctrl_q[`TSES_CTRL_SCAN+1:`TSES_CTRL_SCAN];
  wire [31:0] sync_cyc = variant ? SYNC_B_CYC : SYNC_A_CYC;
  wire [31:0] ton_cyc = variant ? TON_B_CYC : TON_A_CYC;
  // reduced scan and binning pick shorter readout
  // readout table
  wire [31:0] ro_cyc = (variant ? RO_TAB_B[scan] : RO_TAB_A[scan]) * CYC_PER_US;
  wire [31:0] exp_cyc = us_to_cyc({4'h0, exp_us_q});
  wire [31:0] exp_len = (exp_cyc == 32'h0) ? 32'h1 : exp_cyc;
  wire [31:0] dly_cyc = us_to_cyc({4'h0, dly_q});
  wire [31:0] req_cyc = us_to_cyc(req_us_q);

  wire [31:0] base_per = sync_cyc + ton_cyc + exp_cyc + (strobe_en ? ro_cyc : 32'h0);
  wire use_dly = trig_en & ~dly_counts & (dly_cyc > base_per);
  wire [31:0] trig_per = use_dly ? dly_cyc : base_per;
  wire [31:0] min_per = (ro_cyc > trig_per) ? ro_cyc : trig_per;

  // bus slave: one wait cycle on every access
  wire req = avs_read | avs_write;
  wire wr_take = avs_write & ack_q;
  wire wr_ctrl = wr_take & (avs_address == `TSES_REG_CTRL);
  wire wr_exp = wr_take & (avs_address == `TSES_REG_EXPOSURE);
  wire wr_dly = wr_take & (avs_address == `TSES_REG_DELAY);
  wire wr_rate = wr_take & (avs_address == `TSES_REG_RATE_REQ);
  wire wr_stat = wr_take & (avs_address == `TSES_REG_STATUS);
  wire [31:0] new_req_cyc = us_to_cyc(avs_writedata[23:0]);
  wire rate_ok = (avs_writedata[23:0] != 24'h0) & (new_req_cyc >= min_per);
  wire [31:0] rd_mux =
    (avs_address == `TSES_REG_CTRL) ? {24'h0, fixed_q, ctrl_q} :
    (avs_address == `TSES_REG_EXPOSURE) ? {12'h000, exp_us_q} :
    (avs_address == `TSES_REG_DELAY) ? {12'h000, dly_q} :
    (avs_address == `TSES_REG_RATE_REQ) ? {8'h00, req_us_q} :
    (avs_address == `TSES_REG_STATUS) ? {28'h0, ro_pend_q, ro_act_q, fixed_q, missed_q} :
    (avs_address == `TSES_REG_MIN_PERIOD) ? min_per :
    (avs_address == `TSES_REG_MAX_RATE) ? rate_q :
    (avs_address == `TSES_REG_MISSED) ? {16'h0000, miss_cnt_q} : 32'h0;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = avs_readdata_q;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      avs_readdata_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        avs_readdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `TSES_CTRL_RESET;
      exp_us_q <= `TSES_EXPOSURE_RESET;
      dly_q <= `TSES_DELAY_RESET;
      req_us_q <= `TSES_RATE_REQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata[6:0];
      end
      if (wr_exp) begin
        exp_us_q <= avs_writedata[19:0];
      end
      if (wr_dly) begin
        dly_q <= avs_writedata[19:0];
      end
      if (wr_rate & rate_ok) begin
        req_us_q <= avs_writedata[23:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fixed_q <= 1'b0;
    end else if (wr_rate & rate_ok) begin
      fixed_q <= 1'b1;
    end else if (wr_ctrl & ~avs_writedata[`TSES_CTRL_FIXED]) begin
      fixed_q <= 1'b0;
    end
  end

  // trigger pins: three flops, change taken once stages two and three agree
  wire pins_stable = (pos_sync_q[1] == pos_sync_q[2]) & (neg_sync_q[1] == neg_sync_q[2]);
  wire trig_edge = trig_fall ? (trig_prev_q & ~trig_lvl_q) : (~trig_prev_q & trig_lvl_q);
  wire line_tick = (line_cnt_q == 11'(sync_cyc - 32'h1));
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pos_sync_q <= 3'h0;
      neg_sync_q <= 3'h0;
      trig_lvl_q <= 1'b0;
      trig_prev_q <= 1'b0;
      line_cnt_q <= 11'h000;
    end else begin
      pos_sync_q <= {pos_sync_q[1:0], isolated_trigger_in_pos};
      neg_sync_q <= {neg_sync_q[1:0], isolated_trigger_in_neg};
      if (pins_stable) begin
        trig_lvl_q <= pos_sync_q[2] & ~neg_sync_q[2];
      end
      trig_prev_q <= trig_lvl_q;
      line_cnt_q <= line_tick ? 11'h000 : line_cnt_q + 11'h001;
    end
  end

  // frame start conditions
  wire ro_busy = (ro_cnt_q != 32'h0);
  // accept only when idle and enabled
  wire trig_take = trig_en & trig_edge & (state_q == TSES_IDLE) & ~ro_pend_q;
  wire missed = trig_en & trig_edge & ~trig_take;
  wire start_free = ~trig_en & ~fixed_q;
  wire start_fixed = ~trig_en & fixed_q & ((since_q + ton_cyc + 32'h1) >= req_cyc);
  wire start_int = (start_free | start_fixed) & ~ro_pend_q;
  wire wait_ro = strobe_en & (ro_busy | ro_pend_q);
  wire exp_end = (state_q == TSES_EXPOSE) & (timer_q <= 32'h1);

  always_comb begin
    state_d = state_q;
    timer_d = (timer_q != 32'h0) ? timer_q - 32'h1 : 32'h0;
    unique case (state_q)
      TSES_IDLE: begin
        if (trig_take) begin
          state_d = TSES_SYNC;
        end else if (start_int) begin
          state_d = wait_ro ? TSES_WAIT_RO : TSES_TURN_ON;
          timer_d = ton_cyc;
        end
      end
      TSES_SYNC: begin
        if (line_tick) begin
          state_d = TSES_DELAY;
          timer_d = dly_counts ? {12'h000, dly_q} : dly_cyc;
        end
      end
      // delay in cycles or encoder steps
      TSES_DELAY: begin
        if (dly_counts & ~encoder_step) begin
          timer_d = timer_q;
        end
        if (timer_q == 32'h0) begin
          state_d = wait_ro ? TSES_WAIT_RO : TSES_TURN_ON;
          timer_d = ton_cyc;
        end
      end
      TSES_WAIT_RO: begin
        timer_d = ton_cyc;
        if (!ro_busy && !ro_pend_q) begin
          state_d = TSES_TURN_ON;
        end
      end
      TSES_TURN_ON: begin
        if (timer_q <= 32'h1) begin
          state_d = TSES_EXPOSE;
          timer_d = exp_len;
        end
      end
      TSES_EXPOSE: begin
        if (exp_end) begin
          state_d = TSES_IDLE;
        end
      end
      default: begin
        state_d = TSES_IDLE;
        timer_d = 32'h0;
      end
    endcase
  end

  // readout start, one held back while busy
  wire ro_start = ~ro_busy & (exp_end | ro_pend_q);
  wire [31:0] ro_cnt_d = ro_start ? ro_cyc : (ro_busy ? ro_cnt_q - 32'h1 : 32'h0);
  wire exp_begin = (state_d == TSES_EXPOSE) & (state_q != TSES_EXPOSE);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= TSES_IDLE;
      timer_q <= 32'h0;
      since_q <= 32'hFFFF_FFFF;
      ro_cnt_q <= 32'h0;
      ro_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      since_q <= exp_begin ? 32'h0 : (since_q == 32'hFFFF_FFFF ? since_q : since_q + 32'h1);
      ro_cnt_q <= ro_cnt_d;
      ro_pend_q <= (exp_end & ro_busy) | (ro_pend_q & ro_busy);
    end
  end

  // registered outputs follow next state so they line up with state_q
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strobe_q <= 1'b0;
      exposure_q <= 1'b0;
      ro_start_q <= 1'b0;
      ro_act_q <= 1'b0;
    end else begin
      // level over turn-on and exposure
      // strobe enabled mid-frame stays dark until readout is idle
      strobe_q <= strobe_en & ((state_d == TSES_TURN_ON) | (state_d == TSES_EXPOSE))
        & (strobe_q | (~ro_busy & ~ro_pend_q));
      exposure_q <= (state_d == TSES_EXPOSE);
      ro_start_q <= ro_start;
      ro_act_q <= (ro_cnt_d != 32'h0);
    end
  end
  assign strobe_out = strobe_q;
  assign exposure_out = exposure_q;
  assign readout_start = ro_start_q;
  assign readout_active = ro_act_q;

  // missed-trigger flag: a new miss beats a software clear
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      missed_q <= 1'b0;
      miss_cnt_q <= 16'h0000;
    end else begin
      missed_q <= missed | (missed_q & ~(wr_stat & avs_writedata[0]));
      if (missed & (miss_cnt_q != 16'hFFFF)) begin
        miss_cnt_q <= miss_cnt_q + 16'h0001;
      end
    end
  end

  // max rate in 0.01 Hz units; serial divide trades latency for area
  wire [32:0] rem_sh = {div_rem_q[31:0], div_quo_q[31]};
  wire rem_ge = (rem_sh >= {1'b0, div_den_q});
  wire [32:0] rem_nx = rem_ge ? rem_sh - {1'b0, div_den_q} : rem_sh;
  wire [31:0] quo_nx = {div_quo_q[30:0], rem_ge};
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_cnt_q <= 6'h00;
      div_rem_q <= 33'h0;
      div_quo_q <= 32'h0;
      div_den_q <= 32'h1;
      rate_q <= 32'h0;
    end else if (div_cnt_q == 6'h00) begin
      div_cnt_q <= 6'h20;
      div_rem_q <= 33'h0;
      div_quo_q <= `TSES_RATE_NUM;
      div_den_q <= min_per;
    end else begin
      div_cnt_q <= div_cnt_q - 6'h01;
      div_rem_q <= rem_nx;
      div_quo_q <= quo_nx;
      if (div_cnt_q == 6'h01) begin
        rate_q <= quo_nx;
      end
    end
  end

  // checks
  logic [31:0] phase_len_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_len_q <= 32'h0;
    end else begin
      phase_len_q <= (state_d != state_q) ? 32'h0 : phase_len_q + 32'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_q);

  turn_on_len_a: assert property ((state_q == TSES_TURN_ON) && (state_d != TSES_TURN_ON) && $stable(variant)
    |-> phase_len_q + 32'h1 == ton_cyc) else $error("turn-on interval wrong");
  exp_len_a: assert property (exp_end && $stable(exp_us_q) |-> phase_len_q + 32'h1 == exp_len)
    else $error("exposure width wrong");
  strobe_drop_a: assert property ($fell(exposure_out) |-> !strobe_out)
    else $error("strobe outlived exposure");
  ro_start_a: assert property (exp_end && !ro_busy |=> readout_start && readout_active)
    else $error("readout not started");
  ro_overlap_a: assert property (readout_start |-> !$past(readout_active))
    else $error("readouts overlap");
  strobe_wait_a: assert property ($rose(strobe_out) |-> !readout_active)
    else $error("strobe during readout");
  miss_flag_a: assert property (missed |=> missed_q && state_q != TSES_SYNC)
    else $error("missed trigger not flagged");
  trig_gate_a: assert property ((state_q == TSES_SYNC) && ($past(state_q) == TSES_IDLE)
    |-> $past(trig_en)) else $error("trigger taken while disabled");
  sync_bound_a: assert property ((state_q == TSES_SYNC) |-> phase_len_q < SYNC_B_CYC)
    else $error("line sync too long");
  fixed_clear_a: assert property (wr_ctrl && !avs_writedata[`TSES_CTRL_FIXED] |=> !fixed_q)
    else $error("fixed mode not cleared");
  max_rate_a: assert property (div_cnt_q == 6'h01 |=>
    ({32'h0, rate_q} * {32'h0, div_den_q} <= {32'h0, `TSES_RATE_NUM})
    && ({32'h0, rate_q + 32'h1} * {32'h0, div_den_q} > {32'h0, `TSES_RATE_NUM}))
    else $error("max rate quotient wrong");

  strobed_frame_c: cover property (strobe_en && $rose(exposure_out) ##[1:300] $fell(exposure_out));
  missed_c: cover property (missed);
  pending_c: cover property (exp_end && ro_busy);
  fixed_c: cover property (wr_rate && rate_ok);

endmodule

/* File: design/tses_defines.svh */
`ifndef TSES_DEFINES_SVH
`define TSES_DEFINES_SVH
`define TSES_CLK_NS 50
`define TSES_NS_PER_US 1000
`define TSES_CYC_PER_US (`TSES_NS_PER_US / `TSES_CLK_NS)
`define TSES_SYNC_A_NS 31200
`define TSES_SYNC_B_NS 71600
`define TSES_TURNON_A_NS 156000
`define TSES_TURNON_B_NS 143200
`define TSES_RATE_NUM 32'h7735_9400
`define TSES_REG_CTRL 6'h00
`define TSES_REG_EXPOSURE 6'h04
`define TSES_REG_DELAY 6'h08
`define TSES_REG_RATE_REQ 6'h0C
`define TSES_REG_STATUS 6'h10
`define TSES_REG_MIN_PERIOD 6'h14
`define TSES_REG_MAX_RATE 6'h18
`define TSES_REG_MISSED 6'h1C
`define TSES_CTRL_TRIG_EN 0
`define TSES_CTRL_TRIG_FALL 1
`define TSES_CTRL_STROBE_EN 2
`define TSES_CTRL_DLY_COUNTS 3
`define TSES_CTRL_VARIANT 4
`define TSES_CTRL_SCAN 5
`define TSES_CTRL_FIXED 7
`define TSES_CTRL_RESET 7'h00
`define TSES_EXPOSURE_RESET 20'h003E8
`define TSES_DELAY_RESET 20'h00000
`define TSES_RATE_REQ_RESET 24'h000000
`endif

/* File: design/tses_pkg.sv */
package tses_pkg;
  typedef enum logic [5:0] {
    TSES_IDLE = 6'b000001,
    TSES_SYNC = 6'b000010,
    TSES_DELAY = 6'b000100,
    TSES_WAIT_RO = 6'b001000,
    TSES_TURN_ON = 6'b010000,
    TSES_EXPOSE = 6'b100000
  } tses_state_type;
  typedef enum logic [1:0] {
    TSES_SCAN_FULL = 2'h0,
    TSES_SCAN_HALF = 2'h1,
    TSES_SCAN_QUARTER = 2'h2,
    TSES_SCAN_BIN = 2'h3
  } tses_scan_type;
endpackage

/* File: testbench/tses_partner.sv */
`timescale 1ns/100ps
module tses_partner (
  // clock
  input wire logic clock,
  // trigger pair and encoder
  output logic isolated_trigger_in_pos,
  output logic isolated_trigger_in_neg,
  output logic encoder_step,
  // lighting controller
  input wire logic strobe_out,
  output int flash_count
);
  logic strobe_seen;
  initial begin
    isolated_trigger_in_pos = 1'b0;
    isolated_trigger_in_neg = 1'b1;
    encoder_step = 1'b0;
    flash_count = 0;
    strobe_seen = 1'b0;
  end
  always @(posedge clock) begin
    if (strobe_out === 1'b1 && strobe_seen !== 1'b1) flash_count++;
    strobe_seen = strobe_out;
  end
  // spacing left to caller, so over-rate can be forced
  task automatic set_level(input logic v);
    @(posedge clock);
    isolated_trigger_in_pos <= v;
    isolated_trigger_in_neg <= ~v;
  endtask
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge clock);
      encoder_step <= 1'b1;
      @(posedge clock);
      encoder_step <= 1'b0;
    end
  endtask
endmodule

/* File: testbench/tses_sequencer_tb_top.sv */
`timescale 1ns/100ps
`include "tses_defines.svh"
module tses_sequencer_tb_top;
  logic clock, reset_n, avs_read, avs_write, avs_waitrequest, trig_pos, trig_neg, enc_step;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic strobe_out, exposure_out, readout_start, readout_active, exp_d, stb_d, ro_busy_at_stb;
  int flash_count, err_count, n_checks, cyc, n_exp, exp_rise, exp_fall, stb_rise, stb_fall, ro_at, p0, n0, t0;
  // readout times kept short so frames stay cheap
  localparam int RO_US [8] = '{40, 30, 20, 25, 60, 45, 35, 50};
  tses_sequencer #(.RO_FULL_A_US(RO_US[0]), .RO_HALF_A_US(RO_US[1]), .RO_QUARTER_A_US(RO_US[2]),
    .RO_BIN_A_US(RO_US[3]), .RO_FULL_B_US(RO_US[4]), .RO_HALF_B_US(RO_US[5]), .RO_QUARTER_B_US(RO_US[6]),
    .RO_BIN_B_US(RO_US[7])) DUT (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .isolated_trigger_in_pos(trig_pos),
    .isolated_trigger_in_neg(trig_neg), .encoder_step(enc_step), .strobe_out(strobe_out),
    .exposure_out(exposure_out), .readout_start(readout_start), .readout_active(readout_active));
  tses_partner PARTNER (.clock(clock), .isolated_trigger_in_pos(trig_pos), .isolated_trigger_in_neg(trig_neg),
    .encoder_step(enc_step), .strobe_out(strobe_out), .flash_count(flash_count));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (exposure_out === 1'b1 && exp_d !== 1'b1) begin
      n_exp++;
      exp_rise = cyc;
    end
    if (exposure_out !== 1'b1 && exp_d === 1'b1) exp_fall = cyc;
    if (strobe_out === 1'b1 && stb_d !== 1'b1) begin
      stb_rise = cyc;
      ro_busy_at_stb = readout_active;
    end
    if (strobe_out !== 1'b1 && stb_d === 1'b1) stb_fall = cyc;
    if (readout_start === 1'b1) ro_at = cyc;
    exp_d = exposure_out;
    stb_d = strobe_out;
  end
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic check_flag(input string nm, input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %s expected 1 seen %b", nm, ok);
    end
  endtask
  // one wait state expected, but the master waits for it
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && t < 20) begin
      @(posedge clock);
      t++;
    end
    if (t == 20) check_flag("bus_answer", 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic expect_reg(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    check_val(nm, e, q);
  endtask
  task automatic wait_exp(input int k);
    int t;
    t = 0;
    n0 = n_exp;
    while (n_exp < n0 + k && t < 30000) begin
      @(posedge clock);
      t++;
    end
    check_flag("exposure_seen", n_exp >= n0 + k);
  endtask
  function automatic int untrig(input int v, input int sc, input logic stb);
    int t;
    t = (v ? `TSES_SYNC_B_NS + `TSES_TURNON_B_NS : `TSES_SYNC_A_NS + `TSES_TURNON_A_NS) / `TSES_CLK_NS + 100;
    if (stb) t += RO_US[v * 4 + sc] * 20;
    return t;
  endfunction
  task automatic t_reset;
    expect_reg("ctrl", `TSES_REG_CTRL, 32'h0000_0000);
    expect_reg("exposure", `TSES_REG_EXPOSURE, 32'h0000_03E8);
    expect_reg("delay", `TSES_REG_DELAY, 32'h0000_0000);
    wr(6'h20, 32'hFFFF_FFFF);
    expect_reg("unmapped", 6'h20, 32'h0000_0000);
    wr(`TSES_REG_EXPOSURE, 32'h0000_0005);
  endtask
  task automatic t_scan;
    int m, s;
    for (int v = 0; v < 2; v++) begin
      for (int sc = 0; sc < 4; sc++) begin
        wr(`TSES_REG_CTRL, 32'(sc * 32 + v * 16 + 4));
        // divider may need two 33-cycle passes to see the new period
        repeat (80) @(posedge clock);
        m = untrig(v, sc, 1'b1);
        s = `TSES_RATE_NUM / (RO_US[v * 4 + sc] * 20);
        expect_reg("min_period", `TSES_REG_MIN_PERIOD, 32'(m));
        expect_reg("max_rate", `TSES_REG_MAX_RATE, 32'((`TSES_RATE_NUM / m < s) ? `TSES_RATE_NUM / m : s));
      end
    end
    wr(`TSES_REG_CTRL, 32'h0000_0000);
    expect_reg("min_period_nostrobe", `TSES_REG_MIN_PERIOD, 32'(untrig(0, 0, 1'b0)));
  endtask
  task automatic t_freerun;
    wait_exp(1);
    p0 = exp_rise;
    wait_exp(1);
    check_flag("freerun_period", exp_rise - p0 <= untrig(0, 0, 1'b0) + 8 && exp_rise - p0 >= 3220);
    while (exp_fall <= exp_rise) @(posedge clock);
    repeat (2) @(posedge clock);
    check_val("exposure_width", 32'd100, 32'(exp_fall - exp_rise));
    check_flag("readout_after_exposure", ro_at - exp_fall >= 0 && ro_at - exp_fall <= 1);
  endtask
  task automatic t_strobe;
    wr(`TSES_REG_CTRL, 32'h0000_0004);
    wait_exp(2);
    while (exp_fall <= exp_rise) @(posedge clock);
    check_val("turn_on", 32'd3120, 32'(exp_rise - stb_rise));
    check_val("strobe_fall", 32'(exp_fall), 32'(stb_fall));
    check_val("readout_idle_at_strobe", 32'd0, {31'd0, ro_busy_at_stb});
  endtask
  task automatic t_fixed;
    wr(`TSES_REG_RATE_REQ, 32'd150);
    expect_reg("rate_rejected", `TSES_REG_RATE_REQ, 32'h0000_0000);
    wr(`TSES_REG_RATE_REQ, 32'd250);
    bus(1'b0, `TSES_REG_STATUS, 32'h0000_0000, q);
    check_val("fixed_on", 32'd1, {31'd0, q[1]});
    wait_exp(2);
    p0 = exp_rise;
    wait_exp(1);
    check_val("fixed_period", 32'd5000, 32'(exp_rise - p0));
    wr(`TSES_REG_CTRL, 32'h0000_0000);
    bus(1'b0, `TSES_REG_STATUS, 32'h0000_0000, q);
    check_val("fixed_off", 32'd0, {31'd0, q[1]});
  endtask
  task automatic t_trigger;
    int f0, t;
    wr(`TSES_REG_DELAY, 32'd10);
    wr(`TSES_REG_CTRL, 32'h0000_0005);
    repeat (5000) @(posedge clock);
    n0 = n_exp;
    repeat (1000) @(posedge clock);
    check_val("no_frame_untriggered", 32'(n0), 32'(n_exp));
    f0 = flash_count;
    t0 = cyc;
    PARTNER.set_level(1'b1);
    repeat (8) @(posedge clock);
    PARTNER.set_level(1'b0);
    t = 0;
    while (stb_rise <= t0 && t < 2000) begin
      @(posedge clock);
      t++;
    end
    check_flag("trigger_to_strobe", stb_rise - t0 >= 201 && stb_rise - t0 <= 840);
    PARTNER.set_level(1'b1);
    repeat (8) @(posedge clock);
    PARTNER.set_level(1'b0);
    repeat (10) @(posedge clock);
    bus(1'b0, `TSES_REG_STATUS, 32'h0000_0000, q);
    check_val("missed_flag", 32'd1, {31'd0, q[0]});
    expect_reg("missed_count", `TSES_REG_MISSED, 32'd1);
    repeat (6100) @(posedge clock);
    check_val("not_queued", 32'(f0 + 1), 32'(flash_count));
    wr(`TSES_REG_STATUS, 32'h0000_0001);
    bus(1'b0, `TSES_REG_STATUS, 32'h0000_0000, q);
    check_val("missed_cleared", 32'd0, {31'd0, q[0]});
    wr(`TSES_REG_DELAY, 32'd1000);
    bus(1'b0, `TSES_REG_MIN_PERIOD, 32'h0000_0000, q);
    check_flag("timed_delay_in_period", q >= 32'd20000);
  endtask
  task automatic t_encoder;
    // delay of 1000 counts still loaded: it must not lengthen the period
    wr(`TSES_REG_CTRL, 32'h0000_000B);
    expect_reg("count_delay_excluded", `TSES_REG_MIN_PERIOD, 32'(untrig(0, 0, 1'b0)));
    wr(`TSES_REG_DELAY, 32'd3);
    n0 = n_exp;
    PARTNER.set_level(1'b1);
    repeat (700) @(posedge clock);
    PARTNER.steps(3);
    repeat (3400) @(posedge clock);
    check_val("rising_ignored", 32'(n0), 32'(n_exp));
    PARTNER.set_level(1'b0);
    repeat (700) @(posedge clock);
    PARTNER.steps(2);
    repeat (3400) @(posedge clock);
    check_val("two_counts_short", 32'(n0), 32'(n_exp));
    PARTNER.steps(1);
    t0 = cyc;
    wait_exp(1);
    check_flag("count_to_exposure", exp_rise - t0 >= 3118 && exp_rise - t0 <= 3140);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog sized above the longest expected run
  initial begin
    repeat (97000) @(posedge clock);
    err_count++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_scan();
    t_freerun();
    t_strobe();
    t_fixed();
    t_trigger();
    t_encoder();
    summarize();
  end
endmodule
